// ---- src/host_irq_cause_status_upper.v ----
/*
 Host interrupt cause register (upper fields) with host interrupt line.
 Assumes queue and command logic drive event and level inputs on clock_i;
 host register reads arrive as a one-cycle strobe with an address.
*/
// Function
// - Non-wake cause: 2 latency, 3 watermark
// - Bit 5: sync command data in queue
// - Bit 6: async or debug data present
// - Deferred mode moves command responses to bit 6
// - Bit 7 set on fatal-error interrupt
// - Restart flag set at reset, cleared at upload
// - No interrupt line until host configures it
// - Retained config allows interrupt after abnormal reset
// - Clear cause only for channel read
// - Line held until all sources retrieved
// - Non-wake field bits 3-4, 0 none, 1 immediate
`timescale 1ns/1ps
`include "irq_cause_consts.vh"
module host_irq_cause_status_upper (
    input  wire       clock_i,
    input  wire       rstn_i,
    input  wire       rd_strobe_i,
    input  wire [7:0] rd_addr_i,
    input  wire       rd_wake_i,
    input  wire       rd_nwake_i,
    input  wire       rd_status_i,
    input  wire       cfg_wr_i,
    input  wire       cfg_line_en_i,
    input  wire       retained_cfg_i,
    input  wire       abnormal_rst_i,
    input  wire       wake_imm_i,
    input  wire       wake_lat_i,
    input  wire       wake_wm_i,
    input  wire       nwake_imm_i,
    input  wire       nwake_lat_i,
    input  wire       nwake_wm_i,
    input  wire       deferred_mode_i,
    input  wire       cmd_data_i,
    input  wire       async_data_i,
    input  wire       status_empty_i,
    input  wire       fatal_i,
    input  wire       upload_start_i,
    output reg  [7:0] rd_data_o,
    output reg        host_irq_o
);
    localparam NQ       = 2;
    localparam ST_RESET = 2'h0;
    localparam ST_INIT  = 2'h1;
    localparam ST_RUN   = 2'h2;

    // Queue entries: index 0 is the wake-up queue, index 1 the non-wake-up one
    wire [NQ-1:0]   q_imm;
    wire [NQ-1:0]   q_lat;
    wire [NQ-1:0]   q_wm;
    wire [NQ-1:0]   q_read;
    wire [2*NQ-1:0] q_cause;
    wire [1:0]      wake_cause;
    wire [1:0]      nwake_cause;
    reg  [1:0]      init_st_r;
    reg  [1:0]      init_st_nxt;
    wire            init_done;
    reg             sync_r;
    reg             sync_nxt;
    reg             async_r;
    reg             async_nxt;
    reg             restart_r;
    reg             restart_nxt;
    reg             line_en_r;
    reg             line_en_nxt;
    reg             irq_nxt;
    reg  [7:0]      rd_data_nxt;
    wire            rd_hit;
    wire            rearm_ok;
    wire            any_src;
    wire [7:0]      cause_word;
    wire            unused_ok;

    assign q_imm  = {nwake_imm_i, wake_imm_i};
    assign q_lat  = {nwake_lat_i, wake_lat_i};
    assign q_wm   = {nwake_wm_i, wake_wm_i};
    assign q_read = {rd_nwake_i, rd_wake_i};

    // One latch per queue; a read clears only its own queue
    genvar g;
    generate
        for (g = 0; g < NQ; g = g + 1) begin : g_queue
            queue_cause_latch u_latch (
                .clock_i (clock_i),
                .rstn_i  (rstn_i),
                .imm_i   (q_imm[g]),
                .lat_i   (q_lat[g]),
                .wm_i    (q_wm[g]),
                .read_i  (q_read[g]),
                .cause_o (q_cause[2*g+1:2*g])
            );
        end
    endgenerate

    assign wake_cause  = q_cause[1:0];
    assign nwake_cause = q_cause[3:2];

    // Init sequence: first cycle after reset, waiting for upload, running
    always @* begin
        init_st_nxt = init_st_r;
        case (init_st_r)
            ST_RESET:
                init_st_nxt = ST_INIT;
            ST_INIT:
                if (upload_start_i)
                    init_st_nxt = ST_RUN;
            ST_RUN:
                init_st_nxt = ST_RUN;
            default:
                init_st_nxt = ST_RESET;
        endcase
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i)
            init_st_r <= ST_RESET;
        else
            init_st_r <= init_st_nxt;
    end

    // Upload strobes in the very first cycle are ignored
    assign init_done = (init_st_r != ST_RESET);

    // Set wins over the empty indication in the same cycle
    always @* begin
        sync_nxt  = sync_r;
        async_nxt = async_r;
        if (cmd_data_i && !deferred_mode_i)
            sync_nxt = 1'b1;
        else if (status_empty_i)
            sync_nxt = 1'b0;
        if (async_data_i || (cmd_data_i && deferred_mode_i))
            async_nxt = 1'b1;
        else if (status_empty_i)
            async_nxt = 1'b0;
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_r  <= 1'b0;
            async_r <= 1'b0;
        end else begin
            sync_r  <= sync_nxt;
            async_r <= async_nxt;
        end
    end

    // Fatal event wins over an upload start in the same cycle
    always @* begin
        restart_nxt = restart_r;
        if (fatal_i)
            restart_nxt = 1'b1;
        else if (upload_start_i && init_done)
            restart_nxt = 1'b0;
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i)
            restart_r <= 1'b1;
        else
            restart_r <= restart_nxt;
    end

    // Retained config re-arms the line only in the first cycle after reset
    assign rearm_ok = abnormal_rst_i && retained_cfg_i;

    always @* begin
        line_en_nxt = line_en_r;
        if (cfg_wr_i)
            line_en_nxt = cfg_line_en_i;
        else if (!init_done && rearm_ok)
            line_en_nxt = 1'b1;
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i)
            line_en_r <= `LINE_CFG_RESET;
        else
            line_en_r <= line_en_nxt;
    end

    assign any_src = (wake_cause != `QCAUSE_NONE) || (nwake_cause != `QCAUSE_NONE) ||
                     sync_r || async_r || restart_r;

    // Line stays up while any source is pending
    always @* begin
        irq_nxt = 1'b0;
        if (line_en_r && any_src)
            irq_nxt = init_done || !restart_r || rearm_ok;
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i)
            host_irq_o <= 1'b0;
        else
            host_irq_o <= irq_nxt;
    end

    // Bit 0 mirrors the line as registered one cycle earlier
    assign rd_hit     = rd_strobe_i && (rd_addr_i == `HOST_IRQ_CAUSE_ADDR);
    assign cause_word = {restart_r, async_r, sync_r, nwake_cause, wake_cause, host_irq_o};

    // Read-only register; writes have no path here
    always @* begin
        rd_data_nxt = rd_data_o;
        if (rd_hit)
            rd_data_nxt = cause_word;
        else if (rd_strobe_i)
            rd_data_nxt = 8'h00;
    end

    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i)
            rd_data_o <= 8'h00;
        else
            rd_data_o <= rd_data_nxt;
    end

    // Status flags follow the empty level, so the read pulse is not needed
    assign unused_ok = rd_status_i;

endmodule

// ---- src/irq_cause_consts.vh ----
/*
 Constants for the host interrupt cause register: offset, field positions,
 cause codes and reset values. Assumes inclusion by bare name.
*/
`ifndef IRQ_CAUSE_CONSTS_VH
`define IRQ_CAUSE_CONSTS_VH
`define HOST_IRQ_CAUSE_ADDR    8'h2d
`define CAUSE_LINE_BIT         0
`define CAUSE_WAKE_LSB         1
`define CAUSE_NWAKE_LSB        3
`define CAUSE_SYNC_BIT         5
`define CAUSE_ASYNC_BIT        6
`define CAUSE_RESTART_BIT      7
`define QCAUSE_NONE            2'h0
`define QCAUSE_IMMEDIATE       2'h1
`define QCAUSE_LATENCY         2'h2
`define QCAUSE_WATERMARK       2'h3
`define CAUSE_RESET_VALUE      8'h80
`define LINE_CFG_RESET         1'b0
`endif

// ---- src/queue_cause_latch.v ----
/*
 Holds one queue's 2-bit interrupt cause code. A new event code higher than the
 held one, or any code in a read cycle, is latched and held until the host reads that queue's channel.
 Assumes all inputs are synchronous to clock_i.
*/
`timescale 1ns/1ps
`include "irq_cause_consts.vh"
module queue_cause_latch (
    input  wire       clock_i,
    input  wire       rstn_i,
    input  wire       imm_i,
    input  wire       lat_i,
    input  wire       wm_i,
    input  wire       read_i,
    output reg  [1:0] cause_o
);
    reg [1:0] code_nxt;
    always @* begin
        code_nxt = `QCAUSE_NONE;
        if (wm_i)
            code_nxt = `QCAUSE_WATERMARK;
        else if (lat_i)
            code_nxt = `QCAUSE_LATENCY;
        else if (imm_i)
            code_nxt = `QCAUSE_IMMEDIATE;
    end
    // A new event in the read cycle survives; highest code kept until read
    always @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i)
            cause_o <= `QCAUSE_NONE;
        else if (code_nxt != `QCAUSE_NONE && (read_i || code_nxt > cause_o))
            cause_o <= code_nxt;
        else if (read_i)
            cause_o <= `QCAUSE_NONE;
    end
endmodule

// ---- verif/irq_cause_chk_assertions.sv ----
/* Checker for the cause register read path and its flags.
   Bound to the block; sees its ports only. */
`timescale 1ns/1ps
module irq_cause_chk (
    input wire logic       clock_i,
    input wire logic       rstn_i,
    input wire logic       rd_strobe_i,
    input wire logic       upload_start_i,
    input wire logic       fatal_i,
    input wire logic       nwake_wm_i,
    input wire logic       async_data_i,
    input wire logic       cmd_data_i,
    input wire logic       deferred_mode_i,
    input wire logic       cfg_wr_i,
    input wire logic       retained_cfg_i,
    input wire logic       abnormal_rst_i,
    input wire logic       host_irq_o,
    input wire logic [7:0] rd_addr_i,
    input wire logic [7:0] rd_data_o
);
    default clocking dc @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    wire  rd = rd_strobe_i && rd_addr_i == 8'h2d;
    logic up_r;
    // Upload seen since reset: restart flag may then be gone
    always @(posedge clock_i or negedge rstn_i)
        if (!rstn_i) up_r <= 1'b0;
        else up_r <= up_r | upload_start_i;
    logic cfg_r;
    // Line config written since reset
    always @(posedge clock_i or negedge rstn_i)
        if (!rstn_i) cfg_r <= 1'b0;
        else cfg_r <= cfg_r | cfg_wr_i;
    AST_NOLINE: assert property (!cfg_r && !(abnormal_rst_i && retained_cfg_i) |-> !host_irq_o)
        else $error("line driven before config");
    AST_REFUSE: assert property (rd_strobe_i && !rd |=> rd_data_o == 8'h00)
        else $error("other address read nonzero");
    AST_HOLD: assert property (!rd_strobe_i |=> $stable(rd_data_o))
        else $error("read data moved without a read");
    AST_RESTART: assert property (rd && !up_r |=> rd_data_o[7])
        else $error("restart flag missing");
    AST_FATAL: assert property (fatal_i ##[1:2] rd |=> rd_data_o[7])
        else $error("fatal flag missing");
    AST_WMARK: assert property (nwake_wm_i ##[1:2] rd |=> rd_data_o[4:3] == 2'h3)
        else $error("watermark code missing");
    AST_ASYNC: assert property (async_data_i ##[1:2] rd |=> rd_data_o[6])
        else $error("async flag missing");
    AST_DEFER: assert property (cmd_data_i && deferred_mode_i ##[1:2] rd |=> rd_data_o[6])
        else $error("deferred response not on async flag");
    AST_SYNC: assert property (cmd_data_i && !deferred_mode_i ##[1:2] rd |=> rd_data_o[5])
        else $error("sync flag missing");
endmodule
bind host_irq_cause_status_upper irq_cause_chk u_chk (.*);

// ---- verif/host_model.sv ----
/* Host side: single-byte register reads of the cause block.
   Assumes a free-running clock; drives on its falling edge. */
`timescale 1ns/1ps
module host_model (
    input  wire logic       clock_i,
    output logic            rd_strobe_o = 1'b0,
    output logic      [7:0] rd_addr_o = 8'h00,
    input  wire logic [7:0] rd_data_i
);
    // Reads only, the register has no write side
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i) rd_strobe_o = 1'b1;
        rd_addr_o = a;
        @(negedge clock_i) d = rd_data_i;
        rd_strobe_o = 1'b0;
        rd_addr_o = ~a; // Idle address never repeats the last one
    endtask
endmodule

// ---- verif/test_host_irq_cause_status_upper.sv ----
/* Bench: random queue events, status pushes and flag reads against a model.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_host_irq_cause_status_upper;
    logic        clock_i = 0, rstn_i = 0, stb, irq;
    logic [7:0]  adr, d, dat;
    logic [18:0] ev = 0;
    int          bad_count, checked, cyc, wk, nw, r, i;
    host_model u_host (.clock_i, .rd_strobe_o(stb), .rd_addr_o(adr), .rd_data_i(dat));
    host_irq_cause_status_upper u_dut (.clock_i, .rstn_i, .rd_strobe_i(stb), .rd_addr_i(adr),
        .rd_wake_i(ev[0]), .rd_nwake_i(ev[1]), .rd_status_i(ev[2]), .cfg_wr_i(ev[3]),
        .cfg_line_en_i(ev[4]), .retained_cfg_i(ev[5]), .abnormal_rst_i(ev[6]),
        .wake_imm_i(ev[7]), .wake_lat_i(ev[8]), .wake_wm_i(ev[9]), .nwake_imm_i(ev[10]),
        .nwake_lat_i(ev[11]), .nwake_wm_i(ev[12]), .deferred_mode_i(ev[13]),
        .cmd_data_i(ev[14]), .async_data_i(ev[15]), .status_empty_i(ev[16]),
        .fatal_i(ev[17]), .upload_start_i(ev[18]), .rd_data_o(dat), .host_irq_o(irq));
    always #4 clock_i = ~clock_i;
    always @(posedge clock_i) if (++cyc > 3000) begin bad_count++; test_done; end
    task pulse(input logic [18:0] m); @(negedge clock_i) ev |= m; @(negedge clock_i) ev &= ~m; endtask
    task rd; u_host.rd(8'h2d, d); endtask
    task test_done;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        r = $urandom(35);
        ev[16] = 1;
        repeat (10) @(negedge clock_i);
        rstn_i = 1;
        rd; `CK("cause", 8'h80, d)
        u_host.rd(8'h2e, d); `CK("other", 8'h00, d)
        for (i = 0; i < 16; i++) begin
            r = $urandom & 8'hff;
            pulse(19'h80 << r % 3 | 19'h400 << r / 3 % 3);
            wk = wk > r % 3 ? wk : r % 3 + 1; // Higher code wins
            nw = nw > r / 3 % 3 ? nw : r / 3 % 3 + 1;
            rd; `CK("queues", 8'(128 + nw * 8 + wk * 2), d)
            pulse(2); rd; `CK("nwake clear", 8'(128 + wk * 2), d)
            pulse(1); nw = 0; wk = 0;
            ev[13] = r[7]; ev[16] = 0;
            pulse(19'h4000); rd; `CK("command", r[7] ? 2'h2 : 2'h1, d[6:5])
            pulse(19'h8000); rd; `CK("async", r[7] ? 2'h2 : 2'h3, d[6:5])
            ev[16] = 1; pulse(4); rd; `CK("drained", 2'h0, d[6:5])
        end
        $display("queues done");
        pulse(19'h40000); rd; `CK("upload", 1'b0, d[7])
        pulse(19'h20000); rd; `CK("fatal", 1'b1, d[7])
        pulse(19'h418); repeat (3) @(negedge clock_i); `CK("line", 1'b1, irq)
        rstn_i = 0; ev[6:5] = 2'h3; repeat (2) @(negedge clock_i); rstn_i = 1;
        rd; `CK("restart", 1'b1, d[7])
        `CK("rearmed line", 1'b1, irq)
        $display("flags done");
        test_done;
    end
endmodule
